// File: design/op_data_pkg.sv
package op_data_pkg;
    // ***************************
    // command code map
    // ***************************
    localparam logic [12:0] READ_BASE = 13'hC00;
    localparam logic [12:0] WRITE_BASE = 13'h1C00;
    localparam logic [12:0] RANGE_SPAN = 13'h400;
    localparam int RECORD_STRIDE = 32;
    localparam int OFFSET_COUNT = 32;
    localparam int ITEM_COUNT = 16;
    localparam int RECORD_COUNT = 256;
    // ***************************
    // reset values
    // ***************************
    localparam logic [7:0] ORIGIN_RESET = 8'h00;
    localparam logic [31:0] ITEM_RESET = 32'h0000_0000;
    // ***************************
    // item indexes within a record
    // ***************************
    typedef enum logic [3:0] {
        ITEM_TYPE = 4'h0,
        ITEM_POSITION = 4'h1,
        ITEM_SPEED = 4'h2,
        ITEM_RATE = 4'h3,
        ITEM_STOP = 4'h4,
        ITEM_CURRENT = 4'h5,
        ITEM_COMPLETE_DELAY = 4'h6,
        ITEM_LINK = 4'h7,
        ITEM_NEXT_NUMBER = 4'h8,
        ITEM_AREA_OFFSET = 4'h9,
        ITEM_AREA_WIDTH = 4'hA,
        ITEM_LOOP_COUNT = 4'hB,
        ITEM_LOOP_OFFSET = 4'hC,
        ITEM_LOOP_END = 4'hD,
        ITEM_LOW_EVENT = 4'hE,
        ITEM_HIGH_EVENT = 4'hF
    } item_e;
endpackage

// File: design/operation_data_offset_decoder.sv
// What this block does
// R1: The origin record number is offset 0, so origin 32 makes offsets reach records 32 to 63.
// R2: Offset 0 is read code 3072 and write code 7168 whatever the origin.
// R3: Each further offset adds 32 to both read and write base codes (offset 1 is 3104 and 7200).
// R4: Items 0 to 15 of a record sit at base plus 0 to 15 from type to high event.
// R5: Record number wraps modulo 256, so origin 255 plus offset 1 is record 0.
// R6: Offsets end at 31, so the highest codes are read 4064..4079 and write 8160..8175.
// R7: With origin 0 only records 0 to 31 are reachable.
// R8: Read codes return the stored item, write codes update it, other codes are not record accesses.
`timescale 1ns/1ns
`default_nettype none
module operation_data_offset_decoder #(
    parameter int DATA_W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // origin parameter
    input wire logic [7:0] origin,
    // command port
    input wire logic cmd_valid,
    input wire logic [12:0] cmd_code,
    input wire logic [DATA_W-1:0] cmd_wdata,
    // answer port
    output logic rsp_valid,
    output logic rsp_hit,
    output logic rsp_write,
    output logic [7:0] rsp_record,
    output logic [3:0] rsp_item,
    output logic [DATA_W-1:0] rsp_rdata
);
    // ***************************
    // code decode
    // ***************************
    // one bit wider, so the end of the write range does not wrap to zero
    function automatic logic in_range(input logic [12:0] code, input logic [12:0] base);
        logic [13:0] low;
        logic [13:0] high;
        low = {1'b0, base};
        high = {1'b0, base} + {1'b0, op_data_pkg::RANGE_SPAN};
        in_range = ({1'b0, code} >= low) && ({1'b0, code} < high);
    endfunction

    logic is_read;
    logic is_write;
    logic [12:0] rel;
    logic [4:0] offset;
    logic [3:0] item;
    logic [7:0] record;

    always_comb begin
        is_read = in_range(cmd_code, op_data_pkg::READ_BASE); // [R2] [R6]
        is_write = in_range(cmd_code, op_data_pkg::WRITE_BASE); // [R2] [R6]
        rel = is_write ? cmd_code - op_data_pkg::WRITE_BASE : cmd_code - op_data_pkg::READ_BASE;
        offset = rel[9:5]; // [R3] [R6]
        item = rel[3:0]; // [R4]
        record = origin + {3'h0, offset}; // [R1] [R5] [R7]
    end

    // items above 15 inside a 32-code stride are gaps, not record accesses
    logic hit;
    assign hit = cmd_valid && (is_read || is_write) && !rel[4]; // [R8]

    // ***************************
    // record storage
    // ***************************
    logic [DATA_W-1:0] store [op_data_pkg::RECORD_COUNT][op_data_pkg::ITEM_COUNT];
    logic [DATA_W-1:0] next_store [op_data_pkg::RECORD_COUNT][op_data_pkg::ITEM_COUNT];

    always_comb begin
        next_store = store;
        if (hit && is_write) begin
            next_store[record][item] = cmd_wdata; // [R8]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int r = 0; r < op_data_pkg::RECORD_COUNT; r++) begin
                for (int i = 0; i < op_data_pkg::ITEM_COUNT; i++) begin
                    store[r][i] <= op_data_pkg::ITEM_RESET[DATA_W-1:0];
                end
            end
        end else begin
            store <= next_store;
        end
    end

    // ***************************
    // answer registers
    // ***************************
    logic next_rsp_valid;
    logic next_rsp_hit;
    logic next_rsp_write;
    logic [7:0] next_rsp_record;
    logic [3:0] next_rsp_item;
    logic [DATA_W-1:0] next_rsp_rdata;

    always_comb begin
        next_rsp_valid = cmd_valid;
        next_rsp_hit = hit;
        next_rsp_write = hit && is_write;
        next_rsp_record = hit ? record : 8'h00;
        next_rsp_item = hit ? item : 4'h0;
        next_rsp_rdata = '0;
        if (hit && is_read) begin
            next_rsp_rdata = store[record][item]; // [R8]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_hit <= 1'b0;
            rsp_write <= 1'b0;
            rsp_record <= 8'h00;
            rsp_item <= 4'h0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= next_rsp_valid;
            rsp_hit <= next_rsp_hit;
            rsp_write <= next_rsp_write;
            rsp_record <= next_rsp_record;
            rsp_item <= next_rsp_item;
            rsp_rdata <= next_rsp_rdata;
        end
    end

    // ***************************
    // checks
    // ***************************
    origin_base_a: assert property (@(posedge clk) disable iff (rst) // [R2] [R1]
        cmd_valid && (cmd_code == 13'hC00 || cmd_code == 13'h1C00) |=>
        rsp_hit && rsp_record == $past(origin) && rsp_item == 4'h0)
        else $error("base code did not select origin record");
    stride_step_a: assert property (@(posedge clk) disable iff (rst) // [R3]
        cmd_valid && (cmd_code == 13'hC20 || cmd_code == 13'h1C20) |=>
        rsp_record == 8'($past(origin) + 8'h01))
        else $error("offset 1 did not select next record");
    item_index_a: assert property (@(posedge clk) disable iff (rst) // [R4]
        cmd_valid && cmd_code >= 13'h1C00 && cmd_code <= 13'h1C0F |=>
        rsp_item == $past(cmd_code[3:0]) && rsp_write)
        else $error("item index wrong");
    record_wrap_a: assert property (@(posedge clk) disable iff (rst) // [R5]
        cmd_valid && origin == 8'hFF && cmd_code == 13'hC20 |=> rsp_hit && rsp_record == 8'h00)
        else $error("record did not wrap");
    top_code_a: assert property (@(posedge clk) disable iff (rst) // [R6]
        cmd_valid && (cmd_code == 13'h1FEF || cmd_code == 13'hFEF) |=> rsp_hit && rsp_item == 4'hF)
        else $error("highest code not decoded");
    origin_zero_a: assert property (@(posedge clk) disable iff (rst) // [R7]
        rsp_hit && $past(origin) == 8'h00 |-> rsp_record <= 8'h1F)
        else $error("record beyond 31 with origin 0");
    outside_miss_a: assert property (@(posedge clk) disable iff (rst) // [R8]
        cmd_valid && (cmd_code < 13'hC00 || (cmd_code >= 13'h1000 && cmd_code < 13'h1C00)) |=> !rsp_hit)
        else $error("out of range code accepted");
    write_read_a: assert property (@(posedge clk) disable iff (rst) // [R8]
        cmd_valid && cmd_code == 13'h1C05 ##1 cmd_valid && cmd_code == 13'hC05 && $stable(origin)
        |=> rsp_rdata == $past(cmd_wdata, 2))
        else $error("read did not return written value");

    // ***************************
    // answer handshake checks
    // ***************************
    valid_follow_a: assert property (@(posedge clk) disable iff (rst) // [R8]
        cmd_valid |=>
        rsp_valid)
        else $error("command got no answer");

    idle_quiet_a: assert property (@(posedge clk) disable iff (rst) // [R8]
        !cmd_valid |=>
        !rsp_valid && !rsp_hit && !rsp_write)
        else $error("answer without command");

    miss_zero_a: assert property (@(posedge clk) disable iff (rst) // [R8]
        rsp_valid && !rsp_hit |->
        rsp_record == 8'h00 && rsp_item == 4'h0 && rsp_rdata == '0 && !rsp_write)
        else $error("miss answer not cleared");

    write_flag_a: assert property (@(posedge clk) disable iff (rst) // [R8]
        rsp_write |->
        rsp_hit && rsp_valid && rsp_rdata == '0)
        else $error("write answer malformed");

    // ***************************
    // range and selection checks
    // ***************************
    read_range_a: assert property (@(posedge clk) disable iff (rst) // [R2]
        cmd_valid && cmd_code >= 13'hC00 && cmd_code <= 13'hFFF && !cmd_code[4] |=>
        rsp_hit && !rsp_write)
        else $error("read code not decoded as read");

    write_range_a: assert property (@(posedge clk) disable iff (rst) // [R2]
        cmd_valid && cmd_code >= 13'h1C00 && !cmd_code[4] |=>
        rsp_hit && rsp_write)
        else $error("write code not decoded as write");

    item_read_a: assert property (@(posedge clk) disable iff (rst) // [R4]
        cmd_valid && cmd_code >= 13'hC00 && cmd_code <= 13'hC0F |=>
        rsp_hit && !rsp_write && rsp_item == $past(cmd_code[3:0]))
        else $error("read item index wrong");

    origin_upper_a: assert property (@(posedge clk) disable iff (rst) // [R1]
        cmd_valid && origin == 8'h20 && (cmd_code == 13'hFE0 || cmd_code == 13'h1FE0) |=>
        rsp_hit && rsp_record == 8'h3F)
        else $error("origin 32 did not reach record 63");

    last_offset_a: assert property (@(posedge clk) disable iff (rst) // [R6]
        cmd_valid && (cmd_code == 13'hFE0 || cmd_code == 13'h1FE0) |=>
        rsp_hit && rsp_item == 4'h0 && rsp_record == 8'($past(origin) + 8'h1F))
        else $error("last offset selected wrong record");

    wrap_last_a: assert property (@(posedge clk) disable iff (rst) // [R5]
        cmd_valid && origin == 8'hFF && (cmd_code == 13'hFE0 || cmd_code == 13'h1FE0) |=>
        rsp_hit && rsp_record == 8'h1E)
        else $error("wrapped last offset wrong");

    gap_miss_a: assert property (@(posedge clk) disable iff (rst) // [R8]
        cmd_valid && cmd_code[4] && (cmd_code[12:10] == 3'h3 || cmd_code[12:10] == 3'h7) |=>
        !rsp_hit && !rsp_write && rsp_rdata == '0)
        else $error("gap item treated as record access");

    // ***************************
    // storage checks
    // ***************************
    write_store_a: assert property (@(posedge clk) disable iff (rst) // [R8]
        hit && is_write |=>
        store[$past(record)][$past(item)] == $past(cmd_wdata))
        else $error("write did not land in storage");

    read_store_a: assert property (@(posedge clk) disable iff (rst) // [R8]
        hit && is_read |=>
        rsp_rdata == $past(store[record][item]))
        else $error("read returned wrong stored word");
endmodule
`default_nettype wire

// File: verification/net_master.sv
`timescale 1ns/1ns
`default_nettype none
module net_master (
    // clock
    input wire logic clk,
    // command port
    output logic cmd_valid,
    output logic [12:0] cmd_code,
    output logic [31:0] cmd_wdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 13'h0000;
        cmd_wdata = 32'h0000_0000;
    end
    // one command, held through its sampling edge
    task automatic issue(input logic [12:0] c, input logic [31:0] d);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_wdata = d;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        cmd_code = ~c;
        cmd_wdata = ~d;
    endtask
    // two commands on consecutive edges, valid held high between them
    task automatic issue_pair(input logic [12:0] c0, input logic [31:0] d0, input logic [12:0] c1);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd_code = c0;
        cmd_wdata = d0;
        @(posedge clk);
        #1;
        cmd_code = c1;
        cmd_wdata = ~d0;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        cmd_code = ~c1;
        cmd_wdata = d0;
    endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] origin = 8'h00;
    logic cmd_valid, rsp_valid, rsp_hit, rsp_write;
    logic [12:0] cmd_code;
    logic [31:0] cmd_wdata, rsp_rdata;
    logic [7:0] rsp_record;
    logic [3:0] rsp_item;
    logic [31:0] mem [0:255][0:15] = '{default: 32'h0000_0000};
    int errors = 0, num_checks = 0, cycles = 0;
    integer seed = 32'hD50C;
    logic [7:0] orgs [3] = '{8'h00, 8'h20, 8'hFF};
    logic [4:0] offs [3] = '{5'h00, 5'h01, 5'h1F};
    net_master net_master_i (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
    operation_data_offset_decoder operation_data_offset_decoder_i (.clk(clk), .rst(rst), .origin(origin),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_hit(rsp_hit), .rsp_write(rsp_write), .rsp_record(rsp_record), .rsp_item(rsp_item),
        .rsp_rdata(rsp_rdata));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic end_sim;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            end_sim;
        end
    end
    // expected decode, worked from the code map
    function automatic logic exp_hit(input logic [12:0] c);
        logic in_read;
        logic in_write;
        in_read = (c >= 13'h0C00) && (c <= 13'h0FFF);
        in_write = (c >= 13'h1C00);
        return (in_read || in_write) && ((c & 13'h001F) < 13'h0010);
    endfunction
    function automatic logic [7:0] exp_record(input logic [7:0] org, input logic [12:0] c);
        logic [12:0] rel;
        rel = (c >= 13'h1C00) ? c - 13'h1C00 : c - 13'h0C00;
        return 8'(org + 8'(rel / 13'h0020));
    endfunction
    task automatic do_op(input logic [12:0] c, input logic [31:0] d);
        logic h;
        logic w;
        logic [7:0] r;
        logic [3:0] k;
        h = exp_hit(c);
        w = h && (c >= 13'h1C00);
        r = exp_record(origin, c);
        k = 4'(c % 13'h0010);
        net_master_i.issue(c, d);
        chk(32'(rsp_valid), 32'h0000_0001);
        chk(32'(rsp_hit), 32'(h));
        chk(32'(rsp_write), 32'(w));
        chk(32'(rsp_record), h ? 32'(r) : 32'h0000_0000);
        chk(32'(rsp_item), h ? 32'(k) : 32'h0000_0000);
        chk(rsp_rdata, (h && !w) ? mem[r][k] : 32'h0000_0000);
        if (w) begin
            mem[r][k] = d;
        end
    endtask
    // write then read of the same item on back-to-back edges
    task automatic do_pair(input logic [12:0] wc, input logic [31:0] d);
        logic [12:0] rc;
        logic [7:0] r;
        rc = wc - 13'h1000;
        r = exp_record(origin, wc);
        net_master_i.issue_pair(wc, d, rc);
        mem[r][4'(wc % 13'h0010)] = d;
        chk(32'(rsp_hit), 32'h0000_0001);
        chk(rsp_rdata, d);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        chk(32'(rsp_valid), 32'h0000_0000);
        // corner origins and offsets, write then read back
        foreach (orgs[o]) begin
            origin = orgs[o];
            foreach (offs[f]) begin
                for (int i = 0; i < 16; i++) begin
                    do_op(13'h1C00 + {3'h0, offs[f], 5'h00} + 13'(i), 32'($random(seed)));
                    do_op(13'h0C00 + {3'h0, offs[f], 5'h00} + 13'(i), 32'h0000_0000);
                end
            end
        end
        $display("test corners done");
        do_op(13'h0BFF, 32'h0000_0001);
        do_op(13'h0C10, 32'h0000_0002);
        do_op(13'h1C10, 32'h0000_0003);
        do_op(13'h0C00, 32'h0000_0000);
        do_op(13'h1000, 32'h0000_0004);
        do_op(13'h0FEF, 32'h0000_0000);
        do_pair(13'h1C05, 32'($random(seed)));
        $display("test gaps and pairs done");
        repeat (300) begin
            origin = 8'($random(seed));
            do_op(13'($random(seed)), 32'($random(seed)));
        end
        $display("test random done");
        // mid-run reset clears answers and storage
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        mem = '{default: 32'h0000_0000};
        chk(32'(rsp_valid), 32'h0000_0000);
        do_op(13'h0C05, 32'h0000_0000);
        $display("test reset done");
        end_sim;
    end
endmodule
`default_nettype wire
